/* File: pmu_seq_pkg.sv */
// Constants and types for the power-management controller access sequencer.
`default_nettype none
package pmu_seq_pkg;
	// Configuration-space register indices of the host controller.
	localparam logic [15:0] CFG_HOST_CONFIG = 16'h00D2;
	localparam logic [15:0] CFG_IO_BASE = 16'h0090;
	// I/O offsets of the host registers relative to the fetched base.
	localparam logic [15:0] OFS_STATUS = 16'h0000;
	localparam logic [15:0] OFS_COMMAND = 16'h0003;
	localparam logic [15:0] OFS_ADDRESS = 16'h0004;
	localparam logic [15:0] OFS_DATA_HIGH = 16'h0005;
	localparam logic [15:0] OFS_DATA_LOW = 16'h0006;
	// Base field: bit 0 only marks the I/O space and is not address.
	localparam logic [15:0] BASE_MASK = 16'hFFFE;
	// Values written by the sequence.
	localparam logic [7:0] HOST_ENABLE = 8'h01;
	localparam logic [7:0] STATUS_CLEAR = 8'h1E;
	localparam logic [6:0] PMU_ADDR7 = 7'h02;
	// Position of the transfer-done flag in the host status register.
	localparam int DONE_BIT = 1;
	// Default number of status polls before giving up.
	localparam int POLL_LIMIT_DEF = 1000;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ENABLE = 4'h1,
		ST_BASE = 4'h2,
		ST_CLEAR = 4'h3,
		ST_ADDR = 4'h4,
		ST_CMD = 4'h5,
		ST_DAT_HI = 4'h6,
		ST_DAT_LO = 4'h7,
		ST_POLL = 4'h8,
		ST_RD_HI = 4'h9,
		ST_RD_LO = 4'hA
	} seq_state_t;
endpackage : pmu_seq_pkg
`default_nettype wire

/* File: pmu_smbus_sequencer.sv */
// Host-side sequencer that drives an SMBus host controller to reach the power-management MCU.
//
// Functional notes
// - Before the first transfer after reset the host interface is enabled by writing 01h to its config register.
// - After enabling, the I/O base is read from the base register and used for all host registers.
// - Before each transaction the host status is cleared by writing 1Eh to it.
// - A command transfer loads target address 04h, which the MCU accepts as its command address.
// - A read transfer loads target address 05h, which the MCU answers for reads.
// - The command code is written after the target address and before waiting for completion.
// - For a command, the parameter high byte goes to data high and the low byte to data low.
// - Completion is detected by polling the transfer-done flag in the host status register.
// - For a read, the high byte comes from data high and the low byte from data low once done.
// - Initialisation (enable, then base) comes first, then clear, address, command, data, wait, read.
`default_nettype none
module pmu_smbus_sequencer
	import pmu_seq_pkg::*;
#(
	parameter int POLL_LIMIT = POLL_LIMIT_DEF
)
(
	// System clock domain
	input wire logic clk,
	input wire logic arst_n,
	input wire logic en,
	// User command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_param,
	// User result
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic rsp_error,
	output logic busy,
	// Host controller register port, link clock domain
	input wire logic link_clk,
	output logic reg_cfg,
	output logic reg_we,
	output logic reg_re,
	output logic [15:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_ack
);

	function automatic logic [15:0] io_addr(input logic [15:0] base, input logic [15:0] ofs);
		io_addr = base + ofs;
	endfunction : io_addr

	// System domain state.
	logic busy_q, busy_d;
	logic req_tgl_q, req_tgl_d;
	logic hold_rd_q, hold_rd_d;
	logic [7:0] hold_code_q, hold_code_d;
	logic [15:0] hold_param_q, hold_param_d;
	logic rsp_valid_q, rsp_valid_d;
	logic [15:0] rsp_data_q, rsp_data_d;
	logic rsp_error_q, rsp_error_d;
	logic done_s1_q, done_s2_q;
	logic done_seen_q, done_seen_d;

	// Link domain state.
	logic en_s1_q, en_s2_q;
	logic req_s1_q, req_s2_q;
	logic req_seen_q, req_seen_d;
	seq_state_t state_q, state_d;
	logic init_q, init_d;
	logic [15:0] io_base_q, io_base_d;
	logic [15:0] polls_q, polls_d;
	logic [15:0] res_q, res_d;
	logic err_q, err_d;
	logic done_tgl_q, done_tgl_d;
	logic reg_cfg_q, reg_cfg_d;
	logic reg_we_q, reg_we_d;
	logic reg_re_q, reg_re_d;
	logic [15:0] reg_addr_q, reg_addr_d;
	logic [7:0] reg_wdata_q, reg_wdata_d;

	assign cmd_ready = en && !busy_q;
	assign busy = busy_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_data = rsp_data_q;
	assign rsp_error = rsp_error_q;
	assign reg_cfg = reg_cfg_q;
	assign reg_we = reg_we_q;
	assign reg_re = reg_re_q;
	assign reg_addr = reg_addr_q;
	assign reg_wdata = reg_wdata_q;

	// Command fields are held stable while busy, so the link side may read them directly.
	always_comb
	begin
		busy_d = busy_q;
		req_tgl_d = req_tgl_q;
		hold_rd_d = hold_rd_q;
		hold_code_d = hold_code_q;
		hold_param_d = hold_param_q;
		rsp_valid_d = 1'b0;
		rsp_data_d = rsp_data_q;
		rsp_error_d = rsp_error_q;
		done_seen_d = done_seen_q;
		if (cmd_valid && cmd_ready)
		begin
			busy_d = 1'b1;
			req_tgl_d = ~req_tgl_q;
			hold_rd_d = cmd_read;
			hold_code_d = cmd_code;
			hold_param_d = cmd_param;
		end
		if (done_s2_q != done_seen_q)
		begin
			done_seen_d = done_s2_q;
			busy_d = 1'b0;
			rsp_valid_d = 1'b1;
			rsp_data_d = res_q;
			rsp_error_d = err_q;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busy_q <= 1'b0;
			req_tgl_q <= 1'b0;
			hold_rd_q <= 1'b0;
			hold_code_q <= 8'h00;
			hold_param_q <= 16'h0000;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= 16'h0000;
			rsp_error_q <= 1'b0;
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_seen_q <= 1'b0;
		end
		else if (en)
		begin
			busy_q <= busy_d;
			req_tgl_q <= req_tgl_d;
			hold_rd_q <= hold_rd_d;
			hold_code_q <= hold_code_d;
			hold_param_q <= hold_param_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_data_q <= rsp_data_d;
			rsp_error_q <= rsp_error_d;
			done_s1_q <= done_tgl_q;
			done_s2_q <= done_s1_q;
			done_seen_q <= done_seen_d;
		end
	end

	// Sequence walker: one register access per state, advanced on acknowledge, except that ST_POLL repeats until the done flag or the poll limit.
	always_comb
	begin
		state_d = state_q;
		req_seen_d = req_seen_q;
		init_d = init_q;
		io_base_d = io_base_q;
		polls_d = polls_q;
		res_d = res_q;
		err_d = err_q;
		done_tgl_d = done_tgl_q;
		if (state_q == ST_IDLE)
		begin
			if (req_s2_q != req_seen_q)
			begin
				req_seen_d = req_s2_q;
				err_d = 1'b0;
				res_d = 16'h0000;
				polls_d = 16'h0000;
				state_d = init_q ? ST_CLEAR : ST_ENABLE;
			end
		end
		else if (reg_ack)
		begin
			unique case (state_q)
				ST_ENABLE: state_d = ST_BASE;
				ST_BASE:
				begin
					io_base_d = reg_rdata & BASE_MASK;
					init_d = 1'b1;
					state_d = ST_CLEAR;
				end
				ST_CLEAR: state_d = ST_ADDR;
				ST_ADDR: state_d = ST_CMD;
				ST_CMD: state_d = hold_rd_q ? ST_POLL : ST_DAT_HI;
				ST_DAT_HI: state_d = ST_DAT_LO;
				ST_DAT_LO: state_d = ST_POLL;
				ST_POLL:
				begin
					if (reg_rdata[DONE_BIT])
					begin
						state_d = hold_rd_q ? ST_RD_HI : ST_IDLE;
						done_tgl_d = hold_rd_q ? done_tgl_q : ~done_tgl_q;
					end
					else if (polls_q == 16'(POLL_LIMIT - 1))
					begin
						err_d = 1'b1;
						state_d = ST_IDLE;
						done_tgl_d = ~done_tgl_q;
					end
					else
					begin
						polls_d = polls_q + 16'h0001;
					end
				end
				ST_RD_HI:
				begin
					res_d[15:8] = reg_rdata[7:0];
					state_d = ST_RD_LO;
				end
				ST_RD_LO:
				begin
					res_d[7:0] = reg_rdata[7:0];
					state_d = ST_IDLE;
					done_tgl_d = ~done_tgl_q;
				end
				default: state_d = ST_IDLE;
			endcase
		end
	end

	// Register port image of the next state, so the strobes come from flip-flops.
	always_comb
	begin
		reg_cfg_d = 1'b0;
		reg_we_d = 1'b0;
		reg_re_d = 1'b0;
		reg_addr_d = 16'h0000;
		reg_wdata_d = 8'h00;
		unique case (state_d)
			ST_ENABLE:
			begin
				reg_cfg_d = 1'b1;
				reg_we_d = 1'b1;
				reg_addr_d = CFG_HOST_CONFIG;
				reg_wdata_d = HOST_ENABLE;
			end
			ST_BASE:
			begin
				reg_cfg_d = 1'b1;
				reg_re_d = 1'b1;
				reg_addr_d = CFG_IO_BASE;
			end
			ST_CLEAR:
			begin
				reg_we_d = 1'b1;
				reg_addr_d = io_addr(io_base_d, OFS_STATUS);
				reg_wdata_d = STATUS_CLEAR;
			end
			ST_ADDR:
			begin
				reg_we_d = 1'b1;
				reg_addr_d = io_addr(io_base_d, OFS_ADDRESS);
				reg_wdata_d = {PMU_ADDR7, hold_rd_q};
			end
			ST_CMD:
			begin
				reg_we_d = 1'b1;
				reg_addr_d = io_addr(io_base_d, OFS_COMMAND);
				reg_wdata_d = hold_code_q;
			end
			ST_DAT_HI:
			begin
				reg_we_d = 1'b1;
				reg_addr_d = io_addr(io_base_d, OFS_DATA_HIGH);
				reg_wdata_d = hold_param_q[15:8];
			end
			ST_DAT_LO:
			begin
				reg_we_d = 1'b1;
				reg_addr_d = io_addr(io_base_d, OFS_DATA_LOW);
				reg_wdata_d = hold_param_q[7:0];
			end
			ST_POLL:
			begin
				reg_re_d = 1'b1;
				reg_addr_d = io_addr(io_base_d, OFS_STATUS);
			end
			ST_RD_HI:
			begin
				reg_re_d = 1'b1;
				reg_addr_d = io_addr(io_base_d, OFS_DATA_HIGH);
			end
			ST_RD_LO:
			begin
				reg_re_d = 1'b1;
				reg_addr_d = io_addr(io_base_d, OFS_DATA_LOW);
			end
			default: reg_addr_d = 16'h0000;
		endcase
	end

	always_ff @(posedge link_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			en_s1_q <= 1'b0;
			en_s2_q <= 1'b0;
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_seen_q <= 1'b0;
			state_q <= ST_IDLE;
			init_q <= 1'b0;
			io_base_q <= 16'h0000;
			polls_q <= 16'h0000;
			res_q <= 16'h0000;
			err_q <= 1'b0;
			done_tgl_q <= 1'b0;
			reg_cfg_q <= 1'b0;
			reg_we_q <= 1'b0;
			reg_re_q <= 1'b0;
			reg_addr_q <= 16'h0000;
			reg_wdata_q <= 8'h00;
		end
		else
		begin
			en_s1_q <= en;
			en_s2_q <= en_s1_q;
			if (en_s2_q)
			begin
				req_s1_q <= req_tgl_q;
				req_s2_q <= req_s1_q;
				req_seen_q <= req_seen_d;
				state_q <= state_d;
				init_q <= init_d;
				io_base_q <= io_base_d;
				polls_q <= polls_d;
				res_q <= res_d;
				err_q <= err_d;
				done_tgl_q <= done_tgl_d;
				reg_cfg_q <= reg_cfg_d;
				reg_we_q <= reg_we_d;
				reg_re_q <= reg_re_d;
				reg_addr_q <= reg_addr_d;
				reg_wdata_q <= reg_wdata_d;
			end
		end
	end

	property p_enable_write;
		@(posedge link_clk) disable iff (!arst_n)
		state_q == ST_ENABLE |-> reg_we_q && reg_cfg_q && reg_wdata_q == 8'h01
			&& reg_addr_q == CFG_HOST_CONFIG;
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write wrong");

	property p_base_capture;
		@(posedge link_clk) disable iff (!arst_n)
		(state_q == ST_BASE && reg_ack && en_s2_q) |=>
			io_base_q == ($past(reg_rdata) & BASE_MASK) && state_q == ST_CLEAR;
	endproperty
	a_base_capture: assert property (p_base_capture) else $error("base not captured");

	property p_status_clear;
		@(posedge link_clk) disable iff (!arst_n)
		state_q == ST_CLEAR |-> reg_we_q && !reg_cfg_q && reg_wdata_q == 8'h1E
			&& reg_addr_q == io_base_q + OFS_STATUS;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status clear wrong");

	property p_write_target;
		@(posedge link_clk) disable iff (!arst_n)
		(state_q == ST_ADDR && !hold_rd_q) |-> reg_we_q && reg_wdata_q == 8'h04;
	endproperty
	a_write_target: assert property (p_write_target) else $error("write target wrong");

	property p_read_target;
		@(posedge link_clk) disable iff (!arst_n)
		(state_q == ST_ADDR && hold_rd_q) |-> reg_we_q && reg_wdata_q == 8'h05;
	endproperty
	a_read_target: assert property (p_read_target) else $error("read target wrong");

	property p_command_order;
		@(posedge link_clk) disable iff (!arst_n)
		(state_q == ST_ADDR && reg_ack && en_s2_q) |=>
			state_q == ST_CMD && reg_wdata_q == hold_code_q
			&& reg_addr_q == io_base_q + OFS_COMMAND;
	endproperty
	a_command_order: assert property (p_command_order) else $error("command out of order");

	property p_param_order;
		@(posedge link_clk) disable iff (!arst_n)
		(state_q == ST_DAT_HI && reg_ack && en_s2_q) |=>
			state_q == ST_DAT_LO && reg_wdata_q == hold_param_q[7:0]
			&& reg_addr_q == io_base_q + OFS_DATA_LOW;
	endproperty
	a_param_order: assert property (p_param_order) else $error("parameter order wrong");

	property p_poll_wait;
		@(posedge link_clk) disable iff (!arst_n)
		(state_q == ST_POLL && reg_ack && en_s2_q && !reg_rdata[DONE_BIT]
			&& polls_q != 16'(POLL_LIMIT - 1)) |=> state_q == ST_POLL && reg_re_q;
	endproperty
	a_poll_wait: assert property (p_poll_wait) else $error("left poll early");

	property p_read_result;
		@(posedge link_clk) disable iff (!arst_n)
		(state_q == ST_RD_LO && reg_ack && en_s2_q) |=>
			state_q == ST_IDLE && res_q[7:0] == $past(reg_rdata[7:0])
			&& done_tgl_q != $past(done_tgl_q);
	endproperty
	a_read_result: assert property (p_read_result) else $error("read result wrong");

	property p_init_order;
		@(posedge link_clk) disable iff (!arst_n)
		(state_q == ST_IDLE && req_s2_q != req_seen_q && en_s2_q && !init_q) |=>
			state_q == ST_ENABLE;
	endproperty
	a_init_order: assert property (p_init_order) else $error("init skipped");

	property p_dir_bit;
		@(posedge link_clk) disable iff (!arst_n)
		state_q == ST_ADDR |-> reg_wdata_q[0] == hold_rd_q && reg_wdata_q[7:1] == PMU_ADDR7;
	endproperty
	a_dir_bit: assert property (p_dir_bit) else $error("direction bit wrong");

endmodule : pmu_smbus_sequencer
`default_nettype wire

/* File: smbus_host_model.sv */
// Behavioural SMBus host controller answering the sequencer's register port.
`default_nettype none
module smbus_host_model
	import pmu_seq_pkg::*;
#(
	parameter logic [15:0] BASE_RAW = 16'h5001
)
(
	// Register port
	input wire logic link_clk,
	input wire logic arst_n,
	input wire logic reg_cfg,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_ack,
	// Bench control
	input wire logic slow,
	input wire logic [3:0] polls,
	input wire logic [15:0] rd_word
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] B = BASE_RAW & 16'hFFFE;
	logic [25:0] log_q [$];
	logic [3:0] wait_n;
	logic [3:0] npoll;
	logic en_q;
	logic req;
	assign req = (reg_we || reg_re) && !reg_ack;
	always @(posedge link_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_ack <= 1'b0;
			reg_rdata <= 16'h0F0F;
			wait_n <= 4'h0;
			npoll <= 4'h0;
			en_q <= 1'b0;
			log_q = {};
		end
		else
		begin
			reg_ack <= 1'b0;
			// Idle read data keeps changing so a stale sample is caught.
			reg_rdata <= ~reg_rdata;
			if (req && wait_n != 4'h0)
				wait_n <= wait_n - 4'h1;
			else if (req)
			begin
				wait_n <= slow ? 4'h3 : 4'h0;
				reg_ack <= 1'b1;
				log_q.push_back({reg_cfg, reg_we, reg_addr, reg_we ? reg_wdata : 8'h00});
				if (reg_cfg && reg_we && reg_addr == CFG_HOST_CONFIG)
					en_q <= (reg_wdata == 8'h01);
				if (reg_cfg && reg_re && reg_addr == CFG_IO_BASE)
					reg_rdata <= BASE_RAW;
				if (!reg_cfg && reg_we && reg_addr == B && reg_wdata == 8'h1E)
					npoll <= 4'h0;
				if (!reg_cfg && reg_re && reg_addr == B)
				begin
					npoll <= npoll + 4'h1;
					reg_rdata <= {14'h0, en_q && polls != 4'h0 && npoll + 4'h1 >= polls, 1'b0};
				end
				if (!reg_cfg && reg_re && reg_addr == B + 16'h5)
					reg_rdata <= {8'h00, rd_word[15:8]};
				if (!reg_cfg && reg_re && reg_addr == B + 16'h6)
					reg_rdata <= {8'h00, rd_word[7:0]};
			end
		end
	end
endmodule : smbus_host_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the power-management access sequencer.
`default_nettype none
module tb;
	import pmu_seq_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic rd;
		logic [7:0] code;
		logic [15:0] param;
		logic [15:0] word;
		logic [3:0] polls;
		logic slow;
		logic [15:0] exp;
		logic err;
	} row_t;
	localparam logic [15:0] B = 16'h5000;
	localparam int POLL_LIM = 4;
	row_t rows [4] = '{
		'{1'b0, 8'h3C, 16'hA55A, 16'h0000, 4'h1, 1'b0, 16'h0000, 1'b0},
		'{1'b1, 8'h81, 16'h0000, 16'h1234, 4'h3, 1'b0, 16'h1234, 1'b0},
		'{1'b0, 8'h00, 16'hFF00, 16'h0000, 4'h2, 1'b1, 16'h0000, 1'b0},
		'{1'b1, 8'hFF, 16'h0000, 16'h00FF, 4'h1, 1'b1, 16'h00FF, 1'b0}};
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic arst_n = 1'b0;
	logic en = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_ready;
	logic cmd_read = 1'b0;
	logic [7:0] cmd_code = 8'h00;
	logic [15:0] cmd_param = 16'h0000;
	logic rsp_valid;
	logic [15:0] rsp_data;
	logic rsp_error;
	logic busy;
	logic reg_cfg;
	logic reg_we;
	logic reg_re;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic reg_ack;
	logic slow = 1'b0;
	logic [3:0] polls = 4'h1;
	logic [15:0] rd_word = 16'h0000;
	logic need_init = 1'b1;
	logic [25:0] exp_q [$];
	int mismatches = 0;
	int comparisons = 0;
	always #4 clk = ~clk;
	initial
	begin
		#13;
		forever #40 link_clk = ~link_clk;
	end
	pmu_smbus_sequencer #(.POLL_LIMIT(POLL_LIM)) pmu_smbus_sequencer_i (.clk(clk), .arst_n(arst_n),
		.en(en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
		.cmd_code(cmd_code), .cmd_param(cmd_param), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_error(rsp_error), .busy(busy), .link_clk(link_clk), .reg_cfg(reg_cfg),
		.reg_we(reg_we), .reg_re(reg_re), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack));
	smbus_host_model smbus_host_model_i (.link_clk(link_clk), .arst_n(arst_n),
		.reg_cfg(reg_cfg), .reg_we(reg_we), .reg_re(reg_re), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .slow(slow),
		.polls(polls), .rd_word(rd_word));
	task automatic fail(input string msg);
		mismatches++;
		$display("[ERR] %0t %s", $time, msg);
	endtask : fail
	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
			fail("flag differs");
	endtask : chk_bit
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
			fail("word differs");
	endtask : chk_word
	task automatic chk_log();
		comparisons++;
		if (smbus_host_model_i.log_q.size() != exp_q.size())
			fail("access count differs");
		else
			foreach (exp_q[i])
			begin
				chk_word(smbus_host_model_i.log_q[i][23:8], exp_q[i][23:8]);
				chk_word({6'h00, smbus_host_model_i.log_q[i][25:24],
					smbus_host_model_i.log_q[i][7:0]}, {6'h00, exp_q[i][25:24], exp_q[i][7:0]});
			end
	endtask : chk_log
	function automatic logic [25:0] acc(logic cw, logic [15:0] ad, logic [7:0] wd);
		return {1'b0, cw, ad, wd};
	endfunction : acc
	task automatic run(input row_t r);
		int n;
		int np;
		exp_q = {};
		if (need_init)
		begin
			exp_q.push_back({2'b11, CFG_HOST_CONFIG, 8'h01});
			exp_q.push_back({2'b10, CFG_IO_BASE, 8'h00});
		end
		exp_q.push_back(acc(1'b1, B, 8'h1E));
		exp_q.push_back(acc(1'b1, B + 16'h4, r.rd ? 8'h05 : 8'h04));
		exp_q.push_back(acc(1'b1, B + 16'h3, r.code));
		if (!r.rd)
		begin
			exp_q.push_back(acc(1'b1, B + 16'h5, r.param[15:8]));
			exp_q.push_back(acc(1'b1, B + 16'h6, r.param[7:0]));
		end
		// A transfer that never sees the done flag polls exactly the limit and reads nothing.
		np = r.err ? POLL_LIM : int'(r.polls);
		for (n = 0; n < np; n++)
			exp_q.push_back(acc(1'b0, B, 8'h00));
		if (r.rd && !r.err)
		begin
			exp_q.push_back(acc(1'b0, B + 16'h5, 8'h00));
			exp_q.push_back(acc(1'b0, B + 16'h6, 8'h00));
		end
		@(negedge clk);
		smbus_host_model_i.log_q = {};
		slow = r.slow;
		polls = r.polls;
		rd_word = r.word;
		cmd_read = r.rd;
		cmd_code = r.code;
		cmd_param = r.param;
		cmd_valid = 1'b1;
		@(negedge clk);
		chk_bit(cmd_ready, 1'b0);
		chk_bit(busy, 1'b1);
		// A second request while busy must be refused.
		cmd_code = ~r.code;
		repeat (3) @(negedge clk);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 3000)
			fail("no response");
		chk_word(rsp_data, r.exp);
		chk_bit(rsp_error, r.err);
		chk_log();
		@(negedge clk);
		chk_bit(rsp_valid, 1'b0);
		need_init = 1'b0;
		$display("test done, code %h", r.code);
	endtask : run
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (20000) @(posedge clk);
		fail("watchdog");
		end_sim();
	end
	initial
	begin
		// Held past two link edges so both domains see reset.
		repeat (24) @(negedge clk);
		arst_n = 1'b1;
		foreach (rows[i])
			run(rows[i]);
		// Done flag never set: poll limit ends the transfer.
		run('{1'b1, 8'h42, 16'h0000, 16'hBEEF, 4'h0, 1'b0, 16'h0000, 1'b1});
		run(rows[0]);
		en = 1'b0;
		@(negedge clk);
		chk_bit(cmd_ready, 1'b0);
		en = 1'b1;
		$display("test done, enable low");
		repeat (4) @(negedge clk);
		// Reset in mid transfer restarts from enable.
		cmd_read = 1'b1;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		repeat (40) @(negedge clk);
		arst_n = 1'b0;
		repeat (24) @(negedge clk);
		chk_bit(busy, 1'b0);
		chk_word(rsp_data, 16'h0000);
		arst_n = 1'b1;
		need_init = 1'b1;
		run(rows[1]);
		$display("test done, reset recovery");
		end_sim();
	end
endmodule : tb
`default_nettype wire
